// ==== src/laser_out_pkg.sv ====
// types, constants and helpers shared by the laser output command handler
// Function
// - switching feedforward from off to on latches the present piezo setpoint
// - while feedforward is on, current equals K times actual minus latched voltage
// - set command without parameter replies NO PARAMETER SPECIFIED, changes nothing
// - on/off parameter other than 0 or 1 replies VALUE OUT OF RANGE only
// - on/off parameter 0 or 1 applies the state, then replies OK
// - feedforward command: 0 turns feedforward off, 1 turns it on
// - feedforward query returns 0 when off, 1 when on
// - modulation command: 0 disables current modulation, 1 enables it
// - modulation query returns 0 when off, 1 when on
// - laser turn-on flashes the power indicator for the turn-on delay first
// - flash length comes from the programmable turn-on delay, not a constant
// - turn-on delay accepted only from 6000 to 60000 ms, else out of range
// - laser command: 0 turns output off, 1 starts the delayed turn-on
// - laser query returns 0 when output off, 1 when on
// - sweep generator on enables frequency modulation, off stops it
// - sweep command: 0 turns the generator off, 1 turns it on
// - sweep query returns 0 when generator off, 1 when on
// - current query returns the measured diode current at execution time
// - temperature query returns the measured diode temperature magnitude
// - diode temperature above the safe limit shuts the laser output down
// - piezo query returns the measured piezo voltage magnitude
package laser_out_pkg;

  // =========================================================
  // timing
  // =========================================================
  localparam int unsigned CLOCK_HZ = 32'h0098_9680;
  localparam int unsigned HZ_PER_MHZ = 32'h000F_4240;
  localparam int unsigned TICK_PERIOD_US = 32'h0000_03E8;
  localparam int unsigned MS_CYCLES = (CLOCK_HZ / HZ_PER_MHZ) * TICK_PERIOD_US;
  localparam int TICK_CNT_W = 16;

  // turn-on delay limits and default, in ms
  localparam logic [31:0] DELAY_MIN_MS = 32'h0000_1770;
  localparam logic [31:0] DELAY_MAX_MS = 32'h0000_EA60;
  localparam logic [15:0] DELAY_DEFAULT_MS = 16'h1770;
  // indicator half period while arming, in ms
  localparam logic [7:0] FLASH_HALF_MS = 8'hFA;
  // diode temperature limit, 0.01 degC units (50.00 degC)
  localparam logic [15:0] TEMP_LIMIT_DEFAULT = 16'h1388;

  // =========================================================
  // commands and answers
  // =========================================================
  typedef enum logic [3:0] {
    CMD_FF_SET,
    CMD_FF_QRY,
    CMD_MOD_SET,
    CMD_MOD_QRY,
    CMD_LASER_SET,
    CMD_LASER_QRY,
    CMD_SWEEP_SET,
    CMD_SWEEP_QRY,
    CMD_DELAY_SET,
    CMD_DELAY_QRY,
    CMD_CURRENT_QRY,
    CMD_TEMP_QRY,
    CMD_PIEZO_QRY
  } cmd_code_t;

  typedef enum logic [1:0] {
    RESP_OK,
    RESP_NO_PARAM,
    RESP_RANGE,
    RESP_VALUE
  } resp_code_t;

  typedef enum logic [1:0] {
    LASER_OFF,
    LASER_ARMING,
    LASER_ON
  } laser_state_t;

  typedef struct packed {
    cmd_code_t code;
    logic has_param;
    logic [31:0] param;
  } cmd_t;

  typedef struct packed {
    resp_code_t code;
    logic [31:0] value;
  } resp_t;

  // =========================================================
  // state records
  // =========================================================
  typedef struct packed {
    logic [TICK_CNT_W-1:0] count;
    logic tick;
  } tick_state_t;

  typedef struct packed {
    laser_state_t laser;
    logic ff_en;
    logic mod_en;
    logic sweep_en;
    logic [15:0] ff_ref;
    logic [15:0] delay_ms;
    logic [15:0] ms_count;
    logic [7:0] flash_count;
    logic flash;
    logic resp_valid;
    resp_t resp;
    logic signed [32:0] ff_current;
  } ctl_state_t;

  // =========================================================
  // helpers
  // =========================================================
  function automatic logic is_onoff_set(input cmd_code_t c);
    return (c == CMD_FF_SET) || (c == CMD_MOD_SET) || (c == CMD_LASER_SET) ||
           (c == CMD_SWEEP_SET);
  endfunction

  function automatic logic signed [32:0] ff_product(input logic signed [15:0] k,
                                                    input logic signed [15:0] actual,
                                                    input logic signed [15:0] setp);
    logic signed [16:0] diff;
    logic signed [32:0] wide_k;
    logic signed [32:0] wide_diff;
    diff = $signed({actual[15], actual}) - $signed({setp[15], setp});
    // widen both factors first so the product is never formed at 17 bits
    wide_k = 33'(k);
    wide_diff = 33'(diff);
    return wide_k * wide_diff;
  endfunction

endpackage

// ==== src/ms_tick_gen.sv ====
// one-millisecond enable pulse divider with restart
`timescale 1ns/1ns
`default_nettype none
module ms_tick_gen
#(
  parameter int unsigned MS_CYCLES = laser_out_pkg::MS_CYCLES
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic restart,
  output logic tick
);
  import laser_out_pkg::*;

  tick_state_t s_reg;
  tick_state_t s_next;

  // =========================================================
  // divider
  // =========================================================
  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (restart)
    begin
      s_next.count = '0;
    end
    else if (s_reg.count == TICK_CNT_W'(MS_CYCLES - 1))
    begin
      s_next.count = '0;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.count = s_reg.count + TICK_CNT_W'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule
`default_nettype wire

// ==== src/laser_output_command_handler.sv ====
// output-control and sense command handler of the laser controller
`timescale 1ns/1ns
`default_nettype none
module laser_output_command_handler
#(
  parameter int unsigned MS_CYCLES = laser_out_pkg::MS_CYCLES,
  parameter logic [15:0] TEMP_LIMIT = laser_out_pkg::TEMP_LIMIT_DEFAULT
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire laser_out_pkg::cmd_t cmd,
  input wire logic signed [15:0] ff_coeff,
  input wire logic signed [15:0] piezo_setpoint,
  input wire logic signed [15:0] piezo_actual,
  input wire logic [15:0] diode_current,
  input wire logic [15:0] diode_temp,
  output logic resp_valid,
  output laser_out_pkg::resp_t resp,
  output logic ff_enable,
  output logic signed [32:0] ff_current,
  output logic modulation_enable,
  output logic sweep_enable,
  output logic laser_output,
  output logic power_indicator,
  output logic over_temp
);
  import laser_out_pkg::*;

  ctl_state_t s_reg;
  ctl_state_t s_next;
  logic ms_tick;
  logic tick_restart;
  logic temp_high;

  assign temp_high = diode_temp > TEMP_LIMIT;
  assign tick_restart = (s_next.laser == LASER_ARMING) && (s_reg.laser != LASER_ARMING);

  ms_tick_gen #(
    .MS_CYCLES(MS_CYCLES)
  ) tick_gen (
    .clock(clock),
    .srst(srst),
    .restart(tick_restart),
    .tick(ms_tick)
  );

  // =========================================================
  // next state
  // =========================================================
  always_comb
  begin
    s_next = s_reg;
    s_next.resp_valid = 1'b0;

    s_next.ff_current = s_reg.ff_en ? ff_product(ff_coeff, piezo_actual, s_reg.ff_ref) : '0;

    if ((s_reg.laser == LASER_ARMING) && ms_tick)
    begin
      if ((s_reg.ms_count + 16'h0001) >= s_reg.delay_ms)
      begin
        s_next.laser = LASER_ON;
        s_next.flash = 1'b0;
      end
      else
      begin
        s_next.ms_count = s_reg.ms_count + 16'h0001;
        if ((s_reg.flash_count + 8'h01) >= FLASH_HALF_MS)
        begin
          s_next.flash_count = '0;
          s_next.flash = ~s_reg.flash;
        end
        else
        begin
          s_next.flash_count = s_reg.flash_count + 8'h01;
        end
      end
    end

    if (cmd_valid)
    begin
      s_next.resp_valid = 1'b1;
      s_next.resp.value = '0;
      s_next.resp.code = RESP_VALUE;
      case (cmd.code)
        CMD_FF_SET, CMD_MOD_SET, CMD_LASER_SET, CMD_SWEEP_SET:
        begin
          if (!cmd.has_param)
          begin
            s_next.resp.code = RESP_NO_PARAM;
          end
          else if (cmd.param > 32'h0000_0001)
          begin
            s_next.resp.code = RESP_RANGE;
          end
          else
          begin
            s_next.resp.code = RESP_OK;
            if (cmd.code == CMD_FF_SET)
            begin
              if (cmd.param[0] && !s_reg.ff_en)
              begin
                s_next.ff_ref = piezo_setpoint;
              end
              s_next.ff_en = cmd.param[0];
            end
            else if (cmd.code == CMD_MOD_SET)
            begin
              s_next.mod_en = cmd.param[0];
            end
            else if (cmd.code == CMD_SWEEP_SET)
            begin
              s_next.sweep_en = cmd.param[0];
            end
            else if (cmd.param[0])
            begin
              if (s_reg.laser == LASER_OFF)
              begin
                s_next.laser = LASER_ARMING;
                s_next.ms_count = '0;
                s_next.flash_count = '0;
                s_next.flash = 1'b1;
              end
            end
            else
            begin
              s_next.laser = LASER_OFF;
              s_next.flash = 1'b0;
            end
          end
        end
        CMD_DELAY_SET:
        begin
          if (!cmd.has_param)
          begin
            s_next.resp.code = RESP_NO_PARAM;
          end
          else if ((cmd.param < DELAY_MIN_MS) || (cmd.param > DELAY_MAX_MS))
          begin
            s_next.resp.code = RESP_RANGE;
          end
          else
          begin
            s_next.resp.code = RESP_OK;
            s_next.delay_ms = cmd.param[15:0];
          end
        end
        CMD_FF_QRY: s_next.resp.value = {31'h0000_0000, s_reg.ff_en};
        CMD_MOD_QRY: s_next.resp.value = {31'h0000_0000, s_reg.mod_en};
        CMD_LASER_QRY: s_next.resp.value = {31'h0000_0000, s_reg.laser == LASER_ON};
        CMD_SWEEP_QRY: s_next.resp.value = {31'h0000_0000, s_reg.sweep_en};
        CMD_DELAY_QRY: s_next.resp.value = {16'h0000, s_reg.delay_ms};
        CMD_CURRENT_QRY: s_next.resp.value = {16'h0000, diode_current};
        CMD_TEMP_QRY: s_next.resp.value = {16'h0000, diode_temp};
        CMD_PIEZO_QRY:
        begin
          s_next.resp.value = {16'h0000, piezo_actual[15] ? 16'(-piezo_actual) : piezo_actual};
        end
        default: s_next.resp.code = RESP_RANGE;
      endcase
    end

    if (temp_high)
    begin
      s_next.laser = LASER_OFF;
      s_next.flash = 1'b0;
    end
  end

  // =========================================================
  // state register
  // =========================================================
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_reg <= '0;
      s_reg.delay_ms <= DELAY_DEFAULT_MS;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign resp_valid = s_reg.resp_valid;
  assign resp = s_reg.resp;
  assign ff_enable = s_reg.ff_en;
  assign ff_current = s_reg.ff_current;
  assign modulation_enable = s_reg.mod_en;
  assign sweep_enable = s_reg.sweep_en;
  assign laser_output = s_reg.laser == LASER_ON;
  assign power_indicator = s_reg.flash;
  assign over_temp = temp_high;

  // =========================================================
  // checks
  // =========================================================
  default clocking chk_clk @(posedge clock);
  endclocking
  default disable iff (srst);

  no_param_reply_a: assert property (
    cmd_valid && (is_onoff_set(cmd.code) || cmd.code == CMD_DELAY_SET) && !cmd.has_param
    |=> resp_valid && resp.code == RESP_NO_PARAM && $stable(s_reg.ff_en) &&
        $stable(s_reg.delay_ms) && $stable(s_reg.mod_en) && $stable(s_reg.sweep_en))
    else $error("missing parameter not answered or state changed");

  onoff_range_a: assert property (
    cmd_valid && is_onoff_set(cmd.code) && cmd.has_param && cmd.param > 32'h0000_0001
    |=> resp.code == RESP_RANGE && $stable(s_reg.mod_en) && $stable(s_reg.sweep_en))
    else $error("bad on/off value not refused");

  onoff_apply_a: assert property (
    cmd_valid && cmd.code == CMD_MOD_SET && cmd.has_param && cmd.param <= 32'h0000_0001
    |=> resp.code == RESP_OK && modulation_enable == $past(cmd.param[0]))
    else $error("modulation set not applied");

  ff_latch_a: assert property (
    $rose(ff_enable) |-> s_reg.ff_ref == $past(piezo_setpoint))
    else $error("feedforward reference not latched");

  ff_calc_a: assert property (
    ff_enable ##1 ff_enable
    |-> ff_current == ff_product($past(ff_coeff), $past(piezo_actual), $past(s_reg.ff_ref)))
    else $error("feedforward current wrong");

  turn_on_delay_a: assert property (
    $rose(laser_output) |-> $past(s_reg.laser) == LASER_ARMING &&
                            $past(s_reg.ms_count) + 16'h0001 >= $past(s_reg.delay_ms))
    else $error("laser energized before delay ran out");

  delay_range_a: assert property (
    cmd_valid && cmd.code == CMD_DELAY_SET && cmd.has_param && cmd.param > DELAY_MAX_MS
    |=> resp.code == RESP_RANGE && $stable(s_reg.delay_ms))
    else $error("out-of-range delay accepted");

  over_temp_off_a: assert property (
    temp_high |=> !laser_output && !power_indicator)
    else $error("laser not shut down on over-temperature");

  laser_query_a: assert property (
    cmd_valid && cmd.code == CMD_LASER_QRY
    |=> resp.code == RESP_VALUE && resp.value[0] == $past(laser_output))
    else $error("laser state query wrong");

  cancel_arm_a: assert property (
    s_reg.laser == LASER_ARMING && cmd_valid && cmd.code == CMD_LASER_SET &&
    cmd.has_param && cmd.param == 32'h0000_0000
    |=> !laser_output && !power_indicator ##1 !laser_output)
    else $error("turn-off did not cancel pending turn-on");

  ff_apply_a: assert property (
    cmd_valid && cmd.code == CMD_FF_SET && cmd.has_param && cmd.param <= 32'h0000_0001
    |=> resp.code == RESP_OK && ff_enable == $past(cmd.param[0]))
    else $error("feedforward set not applied");

  ff_query_a: assert property (
    cmd_valid && cmd.code == CMD_FF_QRY
    |=> resp.code == RESP_VALUE && resp.value == {31'h0000_0000, $past(ff_enable)})
    else $error("feedforward state query wrong");

  mod_query_a: assert property (
    cmd_valid && cmd.code == CMD_MOD_QRY
    |=> resp.code == RESP_VALUE && resp.value == {31'h0000_0000, $past(modulation_enable)})
    else $error("modulation state query wrong");

  sweep_apply_a: assert property (
    cmd_valid && cmd.code == CMD_SWEEP_SET && cmd.has_param && cmd.param <= 32'h0000_0001
    |=> resp.code == RESP_OK && sweep_enable == $past(cmd.param[0]))
    else $error("sweep set not applied");

  sweep_query_a: assert property (
    cmd_valid && cmd.code == CMD_SWEEP_QRY
    |=> resp.code == RESP_VALUE && resp.value == {31'h0000_0000, $past(sweep_enable)})
    else $error("sweep state query wrong");

  laser_start_a: assert property (
    cmd_valid && cmd.code == CMD_LASER_SET && cmd.has_param && cmd.param == 32'h0000_0001 &&
    s_reg.laser == LASER_OFF && !temp_high
    |=> s_reg.laser == LASER_ARMING && power_indicator && !laser_output)
    else $error("turn-on request did not start the delay");

  delay_apply_a: assert property (
    cmd_valid && cmd.code == CMD_DELAY_SET && cmd.has_param && cmd.param >= DELAY_MIN_MS &&
    cmd.param <= DELAY_MAX_MS
    |=> resp.code == RESP_OK && s_reg.delay_ms == $past(cmd.param[15:0]))
    else $error("in-range delay not stored");

  current_query_a: assert property (
    cmd_valid && cmd.code == CMD_CURRENT_QRY
    |=> resp.code == RESP_VALUE && resp.value == {16'h0000, $past(diode_current)})
    else $error("diode current query wrong");

  temp_query_a: assert property (
    cmd_valid && cmd.code == CMD_TEMP_QRY
    |=> resp.code == RESP_VALUE && resp.value == {16'h0000, $past(diode_temp)})
    else $error("diode temperature query wrong");

endmodule
`default_nettype wire

// ==== test/cmd_host.sv ====
// host model that issues commands to the handler
`timescale 1ns/1ns
`default_nettype none
module cmd_host
  import laser_out_pkg::*;
(
  input wire logic clock,
  output var logic cmd_valid,
  output var laser_out_pkg::cmd_t cmd
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // one command per edge, launched just after it
  task automatic send(input cmd_code_t c, input logic hp, input logic [31:0] p);
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd = '{code: c, has_param: hp, param: p};
  endtask
  // released word shows its inverse, never the old value
  task automatic release_bus();
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    cmd.param = ~cmd.param;
  endtask
endmodule
`default_nettype wire

// ==== test/laser_output_command_handler_tb.sv ====
// self-checking bench for the laser output command handler
`timescale 1ns/1ns
`default_nettype none
module laser_output_command_handler_tb;
  import laser_out_pkg::*;
  localparam int unsigned MSC = 4;
  localparam int D = 6001 * MSC;
  localparam int LIMIT = 40000;
  logic clock;
  logic srst;
  logic cmd_valid;
  cmd_t cmd;
  logic signed [15:0] ff_coeff;
  logic signed [15:0] piezo_setpoint;
  logic signed [15:0] piezo_actual;
  logic [15:0] diode_current;
  logic [15:0] diode_temp;
  logic resp_valid;
  resp_t resp;
  logic ff_enable;
  logic signed [32:0] ff_current;
  logic modulation_enable;
  logic sweep_enable;
  logic laser_output;
  logic power_indicator;
  logic over_temp;
  resp_t exp_q[$];
  resp_t e;
  cmd_code_t sets[3] = '{CMD_FF_SET, CMD_MOD_SET, CMD_SWEEP_SET};
  logic signed [63:0] ex;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  int a;
  cmd_host u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd(cmd));
  laser_output_command_handler #(.MS_CYCLES(MSC)) dut (
    .clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
    .ff_coeff(ff_coeff), .piezo_setpoint(piezo_setpoint), .piezo_actual(piezo_actual),
    .diode_current(diode_current), .diode_temp(diode_temp), .resp_valid(resp_valid),
    .resp(resp), .ff_enable(ff_enable), .ff_current(ff_current),
    .modulation_enable(modulation_enable), .sweep_enable(sweep_enable),
    .laser_output(laser_output), .power_indicator(power_indicator), .over_temp(over_temp));
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_compared++;
    if (seen !== want)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic issue(input cmd_code_t c, input logic hp, input logic [31:0] p,
                       input resp_code_t rc, input logic [31:0] v);
    u_host.send(c, hp, p);
    exp_q.push_back('{code: rc, value: v});
  endtask
  // =========================================
  // answer watcher and hang guard
  always @(negedge clock)
    if (resp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(1, 0);
      else
      begin
        e = exp_q.pop_front();
        check(resp.code, e.code);
        if (e.code == RESP_VALUE)
          check(resp.value, e.value);
      end
    end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      report_and_stop();
    end
  end
  // =========================================
  // main sequence
  initial
  begin
    srst = 1'b1;
    void'($urandom(32'hecf3));
    ff_coeff = 16'($urandom);
    piezo_setpoint = 16'($urandom);
    piezo_actual = 16'($urandom);
    diode_current = 16'($urandom);
    diode_temp = 16'($urandom % 32'h0000_1388);
    repeat (8) @(posedge clock);
    #1;
    srst = 1'b0;
    check({ff_enable, modulation_enable, sweep_enable, laser_output, resp_valid}, 0);
    issue(CMD_DELAY_QRY, 1'b0, 32'h0, RESP_VALUE, 32'(DELAY_DEFAULT_MS));
    for (int i = 0; i < 3; i++)
    begin
      issue(sets[i], 1'b0, 32'h0, RESP_NO_PARAM, 32'h0);
      issue(sets[i], 1'b1, 32'h2 + $urandom % 32'h3E8, RESP_RANGE, 32'h0);
      issue(cmd_code_t'(sets[i] + 1), 1'b0, 32'h0, RESP_VALUE, 32'h0);
      issue(sets[i], 1'b1, 32'h1, RESP_OK, 32'h0);
      issue(cmd_code_t'(sets[i] + 1), 1'b0, 32'h0, RESP_VALUE, 32'h1);
      ex = 64'(ff_coeff) * (64'(piezo_actual) - 64'(piezo_setpoint));
      u_host.release_bus();
      piezo_setpoint = 16'($urandom);
      check({ff_enable, modulation_enable, sweep_enable}, 3'h4 >> i);
      repeat (3) step();
      if (i == 0)
        check(ff_current[32:0], ex[32:0]);
      issue(sets[i], 1'b1, 32'h0, RESP_OK, 32'h0);
      issue(cmd_code_t'(sets[i] + 1), 1'b0, 32'h0, RESP_VALUE, 32'h0);
      u_host.release_bus();
      check({ff_enable, modulation_enable, sweep_enable}, 3'h0);
    end
    issue(CMD_DELAY_SET, 1'b0, 32'h0, RESP_NO_PARAM, 32'h0);
    issue(CMD_DELAY_SET, 1'b1, DELAY_MIN_MS - 1, RESP_RANGE, 32'h0);
    issue(CMD_DELAY_SET, 1'b1, DELAY_MAX_MS + 1, RESP_RANGE, 32'h0);
    issue(CMD_DELAY_SET, 1'b1, DELAY_MAX_MS, RESP_OK, 32'h0);
    issue(CMD_DELAY_QRY, 1'b0, 32'h0, RESP_VALUE, DELAY_MAX_MS);
    issue(CMD_DELAY_SET, 1'b1, DELAY_MIN_MS, RESP_OK, 32'h0);
    issue(CMD_DELAY_QRY, 1'b0, 32'h0, RESP_VALUE, DELAY_MIN_MS);
    issue(CMD_DELAY_SET, 1'b1, DELAY_MIN_MS + 32'h0000_0001, RESP_OK, 32'h0);
    issue(CMD_LASER_SET, 1'b1, 32'h2, RESP_RANGE, 32'h0);
    issue(CMD_LASER_SET, 1'b1, 32'h1, RESP_OK, 32'h0);
    issue(CMD_LASER_QRY, 1'b0, 32'h0, RESP_VALUE, 32'h0);
    u_host.release_bus();
    check({power_indicator, laser_output}, 2'h2);
    issue(CMD_LASER_SET, 1'b1, 32'h0, RESP_OK, 32'h0);
    u_host.release_bus();
    repeat (2) step();
    check({power_indicator, laser_output}, 2'h0);
    issue(CMD_LASER_SET, 1'b1, 32'h1, RESP_OK, 32'h0);
    u_host.release_bus();
    n = 0;
    while (laser_output !== 1'b1 && n < D + 10)
    begin
      step();
      n++;
    end
    check(n, D + 1);
    issue(CMD_LASER_QRY, 1'b0, 32'h0, RESP_VALUE, 32'h1);
    u_host.release_bus();
    diode_temp = TEMP_LIMIT_DEFAULT + 16'h1;
    repeat (2) step();
    check({over_temp, laser_output}, 2'h2);
    issue(CMD_LASER_QRY, 1'b0, 32'h0, RESP_VALUE, 32'h0);
    u_host.release_bus();
    diode_temp = 16'($urandom % 32'h0000_1388);
    diode_current = 16'($urandom);
    piezo_actual = 16'($urandom);
    a = piezo_actual;
    step();
    check(laser_output, 1'b0);
    issue(CMD_CURRENT_QRY, 1'b0, 32'h0, RESP_VALUE, {16'h0, diode_current});
    issue(CMD_TEMP_QRY, 1'b0, 32'h0, RESP_VALUE, {16'h0, diode_temp});
    issue(CMD_PIEZO_QRY, 1'b0, 32'h0, RESP_VALUE, 32'(a < 0 ? -a : a));
    u_host.release_bus();
    repeat (3) step();
    check(exp_q.size(), 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
